// [ebg_defines.vh]
// constants for the external bus grant and read timing block
`ifndef EBG_DEFINES_VH
`define EBG_DEFINES_VH
// processor cycle = CLK_DIV clock_i cycles; output clock high for first half
`define EBG_CLK_DIV        4
`define EBG_CNT_W          3
`define EBG_WAIT_W         3
`define EBG_ADDR_W         14
`define EBG_DATA_W         16
// memory space codes
`define EBG_SPACE_DATA     2'h0
`define EBG_SPACE_PROG     2'h1
`define EBG_SPACE_BOOT     2'h2
`endif

// [ebg_bus_grant.v]
// external bus grant and wait-stated read timing
`timescale 1ns/1ps
`default_nettype none
`include "ebg_defines.vh"
module ebg_bus_grant #(
  parameter CLK_DIV = `EBG_CLK_DIV
) (
  input  wire                      clock_i,
  input  wire                      rst_b_i,
  input  wire                      bus_request_n_i,
  input  wire                      read_req_i,
  input  wire [1:0]                read_space_i,
  input  wire [`EBG_ADDR_W-1:0]    read_addr_i,
  input  wire [`EBG_WAIT_W-1:0]    wait_states_i,
  input  wire [`EBG_DATA_W-1:0]    mem_data_i,
  output wire                      processor_clock_output_o,
  output wire                      bus_grant_n_o,
  output wire                      data_memory_select_n_o,
  output wire                      program_memory_select_n_o,
  output wire                      boot_memory_select_n_o,
  output wire                      read_strobe_n_o,
  output wire                      write_strobe_n_o,
  output wire                      bus_drive_en_o,
  output wire [`EBG_ADDR_W-1:0]    mem_addr_o,
  output wire                      read_busy_o,
  output wire                      read_done_o,
  output wire [`EBG_DATA_W-1:0]    read_data_o
);

  localparam integer PH_LAST_I = CLK_DIV - 1;
  localparam integer PH_FALL_I = CLK_DIV / 2;
  localparam [`EBG_CNT_W-1:0] PH_LAST = PH_LAST_I[`EBG_CNT_W-1:0];
  localparam [`EBG_CNT_W-1:0] PH_FALL = PH_FALL_I[`EBG_CNT_W-1:0];
  localparam [1:0] ST_OWN  = 2'h0;
  localparam [1:0] ST_OFF  = 2'h1;
  localparam [1:0] ST_GRNT = 2'h2;
  localparam [1:0] ST_BACK = 2'h3;

  // ==========================================================
  // processor cycle phase
  // ==========================================================
  reg [`EBG_CNT_W-1:0] phase_q;
  wire cyc_end = (phase_q == PH_LAST);

  // phase counter; output clock high for the first half of each cycle
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      phase_q <= {`EBG_CNT_W{1'b0}};
    end else if (cyc_end) begin
      phase_q <= {`EBG_CNT_W{1'b0}};
    end else begin
      phase_q <= phase_q + {{(`EBG_CNT_W-1){1'b0}}, 1'b1};
    end
  end

  reg pclk_q;
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pclk_q <= 1'b1;
    end else begin
      pclk_q <= cyc_end | (phase_q < PH_FALL - {{(`EBG_CNT_W-1){1'b0}}, 1'b1});
    end
  end
  assign processor_clock_output_o = pclk_q;

  // ==========================================================
  // request synchroniser and recognition
  // ==========================================================
  reg req_meta_q;
  reg req_sync_q;
  // two flops; the first is read by nothing else
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      req_meta_q <= 1'b1;
      req_sync_q <= 1'b1;
    end else begin
      req_meta_q <= bus_request_n_i;
      req_sync_q <= req_meta_q;
    end
  end

  // request latched up to the output clock fall counts this cycle,
  // a later one falls through to the next cycle's window; the cycle
  // end acts on the latched value directly, so the grant lands in the
  // very next processor cycle rather than one cycle later
  reg req_seen_q;
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      req_seen_q <= 1'b0;
    end else if (phase_q <= PH_FALL) begin
      req_seen_q <= ~req_sync_q;
    end
  end
  // recognised, or recognised withdrawn, at this processor cycle end
  wire req_rec  = cyc_end & req_seen_q;
  wire req_gone = cyc_end & ~req_seen_q;

  // ==========================================================
  // grant state machine
  // ==========================================================
  reg [1:0] st_q;
  reg [1:0] st_d;
  reg       read_act_q;

  // bus given up only between reads, at processor cycle edges
  always @* begin
    st_d = st_q;
    case (st_q)
      ST_OWN: begin
        if (req_rec && !read_act_q) begin
          st_d = ST_OFF;
        end
      end
      ST_OFF: begin
        st_d = ST_GRNT;
      end
      ST_GRNT: begin
        if (req_gone) begin
          st_d = ST_BACK;
        end
      end
      ST_BACK: begin
        st_d = ST_OWN;
      end
      default: begin
        st_d = ST_OWN;
      end
    endcase
  end

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q <= ST_OWN;
    end else begin
      st_q <= st_d;
    end
  end

  // strobes are off one clock before grant falls and one clock after it rises
  reg grant_n_q;
  reg drive_q;
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      grant_n_q <= 1'b1;
      drive_q   <= 1'b1;
    end else begin
      grant_n_q <= ~(st_d == ST_GRNT);
      drive_q   <= (st_d == ST_OWN);
    end
  end
  assign bus_grant_n_o  = grant_n_q;
  assign bus_drive_en_o = drive_q;

  // ==========================================================
  // wait-stated external read
  // ==========================================================
  reg [`EBG_WAIT_W-1:0] wait_q;
  reg [1:0]             space_q;
  reg [`EBG_ADDR_W-1:0] addr_q;
  reg [`EBG_DATA_W-1:0] data_q;
  reg                   done_q;
  wire start = read_req_i && !read_act_q && st_q == ST_OWN && !req_seen_q && cyc_end;

  // one processor cycle plus one more per wait state
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      read_act_q <= 1'b0;
      wait_q     <= {`EBG_WAIT_W{1'b0}};
      space_q    <= `EBG_SPACE_DATA;
      addr_q     <= {`EBG_ADDR_W{1'b0}};
      data_q     <= {`EBG_DATA_W{1'b0}};
      done_q     <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start) begin
        read_act_q <= 1'b1;
        wait_q     <= wait_states_i;
        space_q    <= read_space_i;
        addr_q     <= read_addr_i;
      end else if (read_act_q && cyc_end) begin
        if (wait_q == {`EBG_WAIT_W{1'b0}}) begin
          read_act_q <= 1'b0;
          data_q     <= mem_data_i;
          done_q     <= 1'b1;
        end else begin
          wait_q <= wait_q - {{(`EBG_WAIT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  // strobe low from quarter into the cycle, released with the final cycle end
  reg rd_n_q;
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_n_q <= 1'b1;
    end else begin
      rd_n_q <= ~(read_act_q && !(cyc_end && wait_q == {`EBG_WAIT_W{1'b0}}));
    end
  end

  // selects forced high whenever the bus is not ours
  wire sel_ok = drive_q & read_act_q;
  assign data_memory_select_n_o    = ~(sel_ok && space_q == `EBG_SPACE_DATA);
  assign program_memory_select_n_o = ~(sel_ok && space_q == `EBG_SPACE_PROG);
  assign boot_memory_select_n_o    = ~(sel_ok && space_q == `EBG_SPACE_BOOT);
  assign read_strobe_n_o           = rd_n_q | ~drive_q;
  assign write_strobe_n_o          = 1'b1;  // writes are outside this block
  assign mem_addr_o  = addr_q;
  assign read_busy_o = read_act_q;
  assign read_done_o = done_q;
  assign read_data_o = data_q;

endmodule
`default_nettype wire

// [ebg_bus_grant_sva.sv]
// assertions on the bus grant and read timing block
`timescale 1ns/1ps
`default_nettype none
module ebg_bus_grant_sva #(parameter CLK_DIV = 4) (
  input wire logic       clock_i,
  input wire logic       rst_b_i,
  input wire logic       bus_request_n_i,
  input wire logic [2:0] wait_states_i,
  input wire logic       bus_grant_n_o,
  input wire logic       data_memory_select_n_o,
  input wire logic       program_memory_select_n_o,
  input wire logic       boot_memory_select_n_o,
  input wire logic       read_strobe_n_o,
  input wire logic       bus_drive_en_o,
  input wire logic       read_busy_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  int lo_q;
  // strobe low counter, cleared while high so each read is measured alone
  always @(posedge clock_i or negedge rst_b_i)
    if (!rst_b_i)
      lo_q <= 0;
    else
      lo_q <= read_strobe_n_o ? 0 : lo_q + 1;
  a_req_seen: assert property ($fell(bus_request_n_i) && bus_grant_n_o && !read_busy_o
    |-> ##[3:8] !bus_grant_n_o) else $error("late grant");
  a_grant_next: assert property ($fell(bus_drive_en_o) |=> $fell(bus_grant_n_o)) else $error("grant lag");
  a_sync_delay: assert property ($fell(bus_request_n_i) && bus_grant_n_o |-> bus_grant_n_o[*3])
    else $error("grant too early");
  a_quiet_grant: assert property (!bus_grant_n_o |-> !bus_drive_en_o && read_strobe_n_o
    && data_memory_select_n_o && program_memory_select_n_o && boot_memory_select_n_o) else $error("bus driven");
  a_reclaim: assert property ($rose(bus_grant_n_o) |-> !bus_drive_en_o ##1 bus_drive_en_o)
    else $error("bad reclaim");
  a_wait_len: assert property ($rose(read_strobe_n_o) |-> lo_q == (wait_states_i + 1) * CLK_DIV - 1)
    else $error("strobe length");
  a_grant_held: assert property (!bus_grant_n_o && !bus_request_n_i |=> !bus_grant_n_o)
    else $error("grant dropped");
  a_grant_end: assert property ($rose(bus_request_n_i) && !bus_grant_n_o |-> ##[2:8] bus_grant_n_o)
    else $error("grant stuck");
  c_grant: cover property ($fell(bus_grant_n_o));
  c_long_read: cover property ($rose(read_strobe_n_o) && wait_states_i == 3'h7);
  c_req_in_read: cover property (read_busy_o && !bus_request_n_i);
endmodule
bind ebg_bus_grant ebg_bus_grant_sva #(.CLK_DIV(CLK_DIV)) u_ebg_bus_grant_sva (.clock_i(clock_i),
  .rst_b_i(rst_b_i), .bus_request_n_i(bus_request_n_i), .wait_states_i(wait_states_i),
  .bus_grant_n_o(bus_grant_n_o), .data_memory_select_n_o(data_memory_select_n_o),
  .program_memory_select_n_o(program_memory_select_n_o), .boot_memory_select_n_o(boot_memory_select_n_o),
  .read_strobe_n_o(read_strobe_n_o), .bus_drive_en_o(bus_drive_en_o), .read_busy_o(read_busy_o));
`default_nettype wire

// [ebg_master_model.sv]
// external master borrowing the bus, plus the memory the bus grant block reads
`timescale 1ns/1ps
`default_nettype none
module ebg_master_model (
  input  wire logic        clock_i,
  input  wire logic        bus_grant_n_i,
  input  wire logic        read_strobe_n_i,
  input  wire logic [13:0] mem_addr_i,
  output var  logic        bus_request_n_o,
  output wire logic [15:0] mem_data_o
);
  // memory answers under the strobe only; inverse otherwise so stale data cannot pass
  assign mem_data_o = read_strobe_n_i ? ~{2'h3, mem_addr_i} : {2'h3, mem_addr_i};
  initial bus_request_n_o = 1'b1;
  // request held for the whole tenure, moved off the sampling edge
  task automatic use_bus(input int hold);
    @(negedge clock_i);
    bus_request_n_o = 1'b0;
    @(negedge clock_i iff bus_grant_n_i === 1'b0);
    repeat (hold) @(negedge clock_i);
    bus_request_n_o = 1'b1;
  endtask
endmodule
`default_nettype wire

// [tb.sv]
// self-checking testbench for the bus grant and read timing block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clock_i, rst_b_i, read_req_i, req_n, gnt_n, data_memory_select_n, program_memory_select_n, boot_memory_select_n, rds, drv, busy, done, pclk, wrs;
  logic [1:0]  space;
  logic [2:0]  ws;
  logic [13:0] addr, maddr;
  logic [15:0] mdata, rdata;
  int          fails = 0;
  int          tests_run = 0;
  ebg_bus_grant u_ebg_bus_grant (.clock_i(clock_i), .rst_b_i(rst_b_i), .bus_request_n_i(req_n),
    .read_req_i(read_req_i), .read_space_i(space), .read_addr_i(addr), .wait_states_i(ws), .mem_data_i(mdata),
    .processor_clock_output_o(pclk), .bus_grant_n_o(gnt_n), .data_memory_select_n_o(data_memory_select_n),
    .program_memory_select_n_o(program_memory_select_n), .boot_memory_select_n_o(boot_memory_select_n), .read_strobe_n_o(rds),
    .write_strobe_n_o(wrs), .bus_drive_en_o(drv), .mem_addr_o(maddr), .read_busy_o(busy),
    .read_done_o(done), .read_data_o(rdata));
  ebg_master_model u_ebg_master_model (.clock_i(clock_i), .bus_grant_n_i(gnt_n), .read_strobe_n_i(rds),
    .mem_addr_i(maddr), .bus_request_n_o(req_n), .mem_data_o(mdata));
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // one read; the strobe length itself is judged by the checker
  task automatic do_read(input logic [1:0] sp, input logic [2:0] w);
    @(negedge clock_i);
    space = sp;
    ws = w;
    addr = {12'h2a5, sp};
    read_req_i = 1'b1;
    @(negedge clock_i iff busy === 1'b1);
    read_req_i = 1'b0;
    check({13'h0, data_memory_select_n, program_memory_select_n, boot_memory_select_n}, {13'h0, 3'b111 ^ (3'b100 >> sp)});
    // busy rises at a cycle end: output clock high for the first half, strobe a quarter late
    check({14'h0, pclk, rds}, 16'h3);
    @(negedge clock_i);
    check({14'h0, pclk, rds}, 16'h2);
    @(negedge clock_i);
    check({14'h0, pclk, wrs}, 16'h1);
    @(negedge clock_i iff done === 1'b1);
    check(rdata, {2'h3, addr});
    $display("read done");
  endtask
  // lend the bus, then watch it come back one clock after the grant
  task automatic bus_hand(input int hold);
    u_ebg_master_model.use_bus(hold);
    check({15'h0, gnt_n}, 16'h0);
    @(negedge clock_i iff gnt_n === 1'b1);
    check({15'h0, drv}, 16'h0);
    @(negedge clock_i);
    check({15'h0, drv}, 16'h1);
    $display("grant done");
  endtask
  // request lands mid read: the grant must wait for the read to finish
  task automatic read_then_grant;
    fork
      do_read(2'h0, 3'h7);
      begin
        @(negedge clock_i iff busy === 1'b1);
        bus_hand(4);
      end
      begin
        @(negedge clock_i iff gnt_n === 1'b0);
        check({15'h0, busy}, 16'h0);
      end
    join
  endtask
  initial begin
    rst_b_i = 1'b0;
    read_req_i = 1'b0;
    space = 2'h0;
    ws = 3'h0;
    addr = 14'h0;
    repeat (12) @(negedge clock_i);
    rst_b_i = 1'b1;
    for (int s = 0; s < 3; s++)
      do_read(s[1:0], 3'(2 * s));
    bus_hand(8);
    read_then_grant();
    wrap_up();
  end
  // whole run is well under 1000 cycles; 3000 leaves ample margin
  initial begin
    #30000;
    fails++;
    wrap_up();
  end
endmodule
`default_nettype wire
